// ===== shared/raf_pkg.sv
// Constants for the receive address filter: register map, field layout,
// reset values and hash parameters.
// Assumes a 32-bit byte-addressed register port and a 48-bit destination
// address whose first octet on the wire sits in bits 47:40.
package raf_pkg;

   // Register byte addresses
   localparam logic [31:0] ADDR_FILTER_CTRL = 32'hff8005c0;
   localparam logic [31:0] ADDR_FILTER_STATUS = 32'hff8005c4;
   localparam logic [31:0] ADDR_FRAME_COUNTS = 32'hff8005c8;
   localparam logic [31:0] ADDR_HASH_WORD0 = 32'hff8005d0;
   localparam logic [31:0] ADDR_HASH_WORD1 = 32'hff8005d4;
   localparam logic [31:0] ADDR_HASH_WORD2 = 32'hff8005d8;
   localparam logic [31:0] ADDR_HASH_WORD3 = 32'hff8005dc;
   localparam logic [31:0] ADDR_STATION0 = 32'hff800440;
   localparam logic [31:0] ADDR_STATION1 = 32'hff800444;
   localparam logic [31:0] ADDR_STATION2 = 32'hff800448;

   // Control register fields
   localparam int CTRL_BROADCAST_BIT = 0;
   localparam int CTRL_HASHED_MC_BIT = 1;
   localparam int CTRL_ALL_MC_BIT = 2;
   localparam int CTRL_EVERYTHING_BIT = 3;
   localparam int CTRL_WIDTH = 4;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // Status register fields
   localparam int STAT_ACCEPT_BIT = 0;
   localparam int STAT_MULTICAST_BIT = 1;
   localparam int STAT_BROADCAST_BIT = 2;
   localparam int STAT_STATION_BIT = 3;
   localparam int STAT_HASH_HIT_BIT = 4;
   localparam int STAT_INDEX_LSB = 8;

   // Table and address geometry
   localparam int HALF_WIDTH = 16;
   localparam int HASH_WORDS = 4;
   localparam int STATION_WORDS = 3;
   localparam int INDEX_WIDTH = 6;
   localparam int DEST_WIDTH = 48;
   localparam int GROUP_BIT = 40;
   localparam logic [15:0] HALF_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [47:0] BROADCAST_ADDR = 48'hffffffffffff;

   // Hash CRC
   localparam logic [31:0] CRC_SEED = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'h04c11db6;
   localparam int HASH_MSB = 28;
   localparam int HASH_LSB = 23;

endpackage

// ===== design/raf_rx_address_filter.sv
// Receive address filter: control, hash table and station address registers
// on a plain register port, and a one-cycle accept/discard decision for each
// destination address the receive datapath presents.
// Assumes rx_dest_valid and rx_dest_addr come from logic on the same clock.
//
// What this block does
// - Everything enable accepts every frame
// - All-multicast enable accepts any multicast frame
// - Hash enable accepts multicast with table bit set
// - Broadcast enable accepts every broadcast frame
// - Six-bit CRC index delivered to filter logic
// - Index selects one of 64 table bits
// - Hash accept needs multicast and bit one
// - Table held in four 16-bit low halves
// - Index 0 first-word lsb, 63 last msb
// - CRC over 48 bits, all-ones seed, bits 28:23
// - Compare destination with three-word station address
`timescale 1ns/10ps

module raf_rx_address_filter
   import raf_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic rx_dest_valid,
   input wire logic [47:0] rx_dest_addr,
   output logic filt_valid,
   output logic filt_accept,
   output logic filt_discard,
   output logic [5:0] filt_hash_index
);

   // Hash index of a destination address. Words are taken first octet high,
   // bits fed lsb first, as the software table builder does.
   function automatic logic [5:0] raf_hash_index(input logic [47:0] da);
      logic [31:0] crc;
      logic [15:0] word;
      logic fb;
      crc = CRC_SEED;
      word = HALF_RESET;
      fb = 1'b0;
      for (int w = 0; w < STATION_WORDS; w++) begin
         word = da[DEST_WIDTH - 1 - HALF_WIDTH * w -: HALF_WIDTH];
         for (int b = 0; b < HALF_WIDTH; b++) begin
            fb = crc[31] ^ word[b];
            crc = {crc[30:0], 1'b0};
            if (fb) begin
               crc = crc ^ CRC_POLY;
            end
            crc[0] = crc[0] | fb;
         end
      end
      return crc[HASH_MSB:HASH_LSB];
   endfunction

   // Word select inside a small register group
   function automatic logic [1:0] raf_word_sel(input logic [31:0] a, input logic [31:0] base);
      logic [31:0] diff;
      diff = a - base;
      return diff[3:2];
   endfunction

   logic [CTRL_WIDTH-1:0] ctrl_r;
   logic [15:0] hash_word_r [0:HASH_WORDS-1];
   logic [15:0] station_r [0:STATION_WORDS-1];
   logic [31:0] rdata_r;
   logic valid_r;
   logic accept_r;
   logic discard_r;
   logic [5:0] index_r;
   logic [15:0] status_r;
   logic [15:0] accept_count_r;
   logic [15:0] discard_count_r;

   logic hit_hash_wr;
   logic hit_station_wr;
   logic [1:0] hash_sel;
   logic [1:0] station_sel;
   logic [5:0] index_nxt;
   logic table_bit;
   logic [47:0] station_addr;
   logic is_multicast;
   logic is_broadcast;
   logic station_hit;
   logic hash_hit;
   logic accept_nxt;
   logic count_clear;
   logic [31:0] rdata_nxt;

   // Address decode
   assign hit_hash_wr = reg_wr && (reg_addr >= ADDR_HASH_WORD0) && (reg_addr <= ADDR_HASH_WORD3)
                        && (reg_addr[1:0] == 2'h0);
   assign hit_station_wr = reg_wr && (reg_addr >= ADDR_STATION0) && (reg_addr <= ADDR_STATION2)
                           && (reg_addr[1:0] == 2'h0);
   assign hash_sel = raf_word_sel(reg_addr, ADDR_HASH_WORD0);
   assign station_sel = raf_word_sel(reg_addr, ADDR_STATION0);
   assign count_clear = reg_wr && (reg_addr == ADDR_FRAME_COUNTS);

   // Control register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_wr && (reg_addr == ADDR_FILTER_CTRL)) begin
         ctrl_r <= reg_wdata[CTRL_WIDTH-1:0];
      end
   end

   // Hash table words, low halves only
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < HASH_WORDS; i++) begin
            hash_word_r[i] <= HALF_RESET;
         end
      end else if (hit_hash_wr) begin
         hash_word_r[hash_sel] <= reg_wdata[HALF_WIDTH-1:0];
      end
   end

   // Station address words
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < STATION_WORDS; i++) begin
            station_r[i] <= HALF_RESET;
         end
      end else if (hit_station_wr && (station_sel < 2'(STATION_WORDS))) begin
         station_r[station_sel] <= reg_wdata[HALF_WIDTH-1:0];
      end
   end

   // Classification of the presented destination
   assign station_addr = {station_r[0], station_r[1], station_r[2]};
   assign is_multicast = rx_dest_addr[GROUP_BIT];
   assign is_broadcast = (rx_dest_addr == BROADCAST_ADDR);
   assign station_hit = (rx_dest_addr == station_addr);

   // Index from the CRC stage feeds the table lookup in the same cycle
   assign index_nxt = raf_hash_index(rx_dest_addr);
   assign table_bit = hash_word_r[index_nxt[5:4]][index_nxt[3:0]];
   assign hash_hit = is_multicast && table_bit;

   // Broadcast carries the group bit, so all-multicast enable also takes it, and hash enable does if its table bit is set
   always_comb begin
      accept_nxt = station_hit;
      if (ctrl_r[CTRL_EVERYTHING_BIT]) begin
         accept_nxt = 1'b1;
      end
      if (ctrl_r[CTRL_ALL_MC_BIT] && is_multicast) begin
         accept_nxt = 1'b1;
      end
      if (ctrl_r[CTRL_HASHED_MC_BIT] && hash_hit) begin
         accept_nxt = 1'b1;
      end
      if (ctrl_r[CTRL_BROADCAST_BIT] && is_broadcast) begin
         accept_nxt = 1'b1;
      end
   end

   // Decision outputs, one cycle after the address is presented
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         valid_r <= 1'b0;
         accept_r <= 1'b0;
         discard_r <= 1'b0;
         index_r <= 6'h00;
      end else begin
         valid_r <= rx_dest_valid;
         accept_r <= rx_dest_valid && accept_nxt;
         discard_r <= rx_dest_valid && !accept_nxt;
         if (rx_dest_valid) begin
            index_r <= index_nxt;
         end
      end
   end

   // Snapshot of the last decision for software
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         status_r <= HALF_RESET;
      end else if (rx_dest_valid) begin
         status_r <= HALF_RESET;
         status_r[STAT_ACCEPT_BIT] <= accept_nxt;
         status_r[STAT_MULTICAST_BIT] <= is_multicast;
         status_r[STAT_BROADCAST_BIT] <= is_broadcast;
         status_r[STAT_STATION_BIT] <= station_hit;
         status_r[STAT_HASH_HIT_BIT] <= hash_hit;
         status_r[STAT_INDEX_LSB +: INDEX_WIDTH] <= index_nxt;
      end
   end

   // Frame counters; a frame in the clearing cycle is still counted
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         accept_count_r <= COUNT_RESET;
         discard_count_r <= COUNT_RESET;
      end else begin
         if (count_clear) begin
            accept_count_r <= (rx_dest_valid && accept_nxt) ? COUNT_ONE : COUNT_RESET;
            discard_count_r <= (rx_dest_valid && !accept_nxt) ? COUNT_ONE : COUNT_RESET;
         end else if (rx_dest_valid) begin
            if (accept_nxt) begin
               accept_count_r <= accept_count_r + COUNT_ONE;
            end else begin
               discard_count_r <= discard_count_r + COUNT_ONE;
            end
         end
      end
   end

   // Read mux; unmapped addresses and misaligned ones read as zero
   always_comb begin
      rdata_nxt = 32'h00000000;
      case (reg_addr)
         ADDR_FILTER_CTRL: rdata_nxt[CTRL_WIDTH-1:0] = ctrl_r;
         ADDR_FILTER_STATUS: rdata_nxt[HALF_WIDTH-1:0] = status_r;
         ADDR_FRAME_COUNTS: rdata_nxt = {discard_count_r, accept_count_r};
         ADDR_HASH_WORD0: rdata_nxt[HALF_WIDTH-1:0] = hash_word_r[0];
         ADDR_HASH_WORD1: rdata_nxt[HALF_WIDTH-1:0] = hash_word_r[1];
         ADDR_HASH_WORD2: rdata_nxt[HALF_WIDTH-1:0] = hash_word_r[2];
         ADDR_HASH_WORD3: rdata_nxt[HALF_WIDTH-1:0] = hash_word_r[3];
         ADDR_STATION0: rdata_nxt[HALF_WIDTH-1:0] = station_r[0];
         ADDR_STATION1: rdata_nxt[HALF_WIDTH-1:0] = station_r[1];
         ADDR_STATION2: rdata_nxt[HALF_WIDTH-1:0] = station_r[2];
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata_r <= 32'h00000000;
      end else begin
         rdata_r <= reg_rd ? rdata_nxt : 32'h00000000;
      end
   end

   assign reg_rdata = rdata_r;
   assign filt_valid = valid_r;
   assign filt_accept = accept_r;
   assign filt_discard = discard_r;
   assign filt_hash_index = index_r;

endmodule // raf_rx_address_filter

// ===== tb/raf_rx_source.sv
// Model of the receive datapath: presents one destination address per call.
// Assumes the filter samples rx_dest_valid on the rising clock edge.
`timescale 1ns/10ps
module raf_rx_source (
   input wire logic clock,
   output logic rx_dest_valid,
   output logic [47:0] rx_dest_addr
);
   initial begin
      rx_dest_valid = 1'b0;
      rx_dest_addr = 48'h0;
   end
   task automatic send(input logic [47:0] a);
      @(posedge clock);
      rx_dest_valid <= 1'b1;
      rx_dest_addr <= a;
      @(posedge clock);
      rx_dest_valid <= 1'b0;
      // Idle address inverted so a stale copy never passes for a frame
      rx_dest_addr <= ~a;
   endtask
endmodule // raf_rx_source

// ===== tb/raf_filter_props.sv
// Port checker for the receive address filter.
// Assumes one clock domain; bound onto the filter at the foot of this file.
`timescale 1ns/10ps
module raf_filter_props
   import raf_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic rx_dest_valid,
   input wire logic [47:0] rx_dest_addr,
   input wire logic filt_valid,
   input wire logic filt_accept,
   input wire logic filt_discard,
   input wire logic [5:0] filt_hash_index
);
   logic [3:0] ctrl_r;
   // Mirror of the control field, old value seen by a frame in the write cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_wr && reg_addr == ADDR_FILTER_CTRL) begin
         ctrl_r <= reg_wdata[3:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   AST_VALID_LAT: assert property (rx_dest_valid |=> filt_valid)
      else $error("filter answer missing");
   AST_NO_SPUR: assert property (!rx_dest_valid |=> !filt_valid)
      else $error("filter answer without frame");
   AST_ONE_OF: assert property (filt_valid |-> filt_accept ^ filt_discard)
      else $error("accept and discard not exclusive");
   AST_QUIET: assert property (!filt_valid |-> !(filt_accept || filt_discard))
      else $error("verdict outside answer cycle");
   AST_EVERY: assert property (rx_dest_valid && ctrl_r[3] |=> filt_accept)
      else $error("frame refused with everything enable");
   AST_ALL_MC: assert property (rx_dest_valid && ctrl_r[2] && rx_dest_addr[GROUP_BIT] |=> filt_accept)
      else $error("multicast refused");
   AST_BCAST: assert property (rx_dest_valid && ctrl_r[0] && rx_dest_addr == BROADCAST_ADDR |=> filt_accept)
      else $error("broadcast refused");
   AST_IDX_HOLD: assert property (!rx_dest_valid |=> $stable(filt_hash_index))
      else $error("hash index moved without frame");
   AST_HASH_RSVD: assert property (reg_rd && reg_addr[31:4] == ADDR_HASH_WORD0[31:4] |=> reg_rdata[31:16] == 16'h0)
      else $error("hash word upper half not zero");
endmodule // raf_filter_props
bind raf_rx_address_filter raf_filter_props i_raf_filter_props (.clock, .reset, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_dest_valid, .rx_dest_addr, .filt_valid,
   .filt_accept, .filt_discard, .filt_hash_index);

// ===== tb/raf_rx_address_filter_tb_top.sv
// Self-checking bench for the receive address filter.
// Assumes raf_pkg, the source model and the bound checker are compiled first.
`timescale 1ns/10ps
module raf_rx_address_filter_tb_top;
   import raf_pkg::*;
   logic clock, reset, reg_wr, reg_rd, rx_dest_valid, filt_valid, filt_accept, filt_discard;
   logic [31:0] reg_addr, reg_wdata, reg_rdata;
   logic [47:0] rx_dest_addr;
   logic [5:0] filt_hash_index;
   int n_fail = 0;
   int n_checks = 0;
   localparam logic [47:0] STN = 48'h021122334455;
   localparam logic [47:0] MC = 48'h01005e000001;
   localparam logic [31:0] UNMAPPED = 32'hff8005e0;
   raf_rx_address_filter i_raf_rx_address_filter (.clock, .reset, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .rx_dest_valid, .rx_dest_addr, .filt_valid,
      .filt_accept, .filt_discard, .filt_hash_index);
   raf_rx_source i_raf_rx_source (.clock, .rx_dest_valid, .rx_dest_addr);
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk("read data", reg_rdata, exp);
   endtask
   // Walks the words high first, each from bit 0 up
   function automatic logic [5:0] hidx(input logic [47:0] a);
      logic [31:0] c;
      logic fb;
      c = CRC_SEED;
      for (int i = 0; i < 48; i++) begin
         fb = c[31] ^ a[32 - 16 * (i / 16) + i % 16];
         c = c << 1;
         if (fb) c = c ^ CRC_POLY;
         c[0] = c[0] | fb;
      end
      return c[HASH_MSB:HASH_LSB];
   endfunction
   task automatic frame(input logic [47:0] a, input logic acc);
      i_raf_rx_source.send(a);
      #1 chk("valid", {31'h0, filt_valid}, 32'h1);
      chk("accept", {31'h0, filt_accept}, {31'h0, acc});
      chk("discard", {31'h0, filt_discard}, {31'h0, !acc});
      chk("index", {26'h0, filt_hash_index}, {26'h0, hidx(a)});
   endtask
   task automatic t_reset();
      logic [31:0] adr[6];
      adr = '{ADDR_FILTER_CTRL, ADDR_HASH_WORD0, ADDR_HASH_WORD1, ADDR_HASH_WORD2,
         ADDR_HASH_WORD3, UNMAPPED};
      foreach (adr[i]) rd(adr[i], 32'h0);
      $display("reset values done");
   endtask
   task automatic t_regs();
      for (int w = 0; w < 4; w++) begin
         wr(ADDR_HASH_WORD0 + 32'(4 * w), 32'hffffffff);
         rd(ADDR_HASH_WORD0 + 32'(4 * w), 32'h0000ffff);
         wr(ADDR_HASH_WORD0 + 32'(4 * w), 32'h0);
      end
      wr(ADDR_FILTER_CTRL, 32'hffffffff);
      rd(ADDR_FILTER_CTRL, 32'h0000000f);
      wr(UNMAPPED, 32'hffffffff);
      rd(UNMAPPED, 32'h0);
      $display("register access done");
   endtask
   task automatic t_modes();
      logic [3:0] c[9];
      logic [47:0] a[9];
      logic e[9];
      c = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h4, 4'h4, 4'h8};
      a = '{MC, BROADCAST_ADDR, STN, STN + 48'h1, BROADCAST_ADDR, MC, MC, STN + 48'h1,
         STN + 48'h1};
      e = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      wr(ADDR_STATION0, {16'h0, STN[47:32]});
      wr(ADDR_STATION1, {16'h0, STN[31:16]});
      wr(ADDR_STATION2, {16'h0, STN[15:0]});
      foreach (c[i]) begin
         wr(ADDR_FILTER_CTRL, {28'h0, c[i]});
         frame(a[i], e[i]);
      end
      rd(ADDR_STATION0, {16'h0, STN[47:32]});
      rd(ADDR_STATION2, {16'h0, STN[15:0]});
      rd(ADDR_FILTER_STATUS, {18'h0, hidx(STN + 48'h1), 8'h01});
      rd(ADDR_FRAME_COUNTS, {16'h0005, 16'h0004});
      wr(ADDR_FRAME_COUNTS, 32'h0);
      rd(ADDR_FRAME_COUNTS, 32'h0);
      $display("acceptance modes done");
   endtask
   task automatic t_hash();
      logic [47:0] a;
      logic [5:0] i;
      wr(ADDR_FILTER_CTRL, 32'h2);
      for (int k = 0; k < 6; k++) begin
         a = MC + 48'(k * 7);
         i = hidx(a);
         frame(a, 1'b0);
         wr(ADDR_HASH_WORD0 + {28'h0, i[5:4], 2'b0}, 32'h1 << i[3:0]);
         frame(a, 1'b1);
         wr(ADDR_HASH_WORD0 + {28'h0, i[5:4], 2'b0}, 32'hffff & ~(32'h1 << i[3:0]));
         frame(a, 1'b0);
         wr(ADDR_HASH_WORD0 + {28'h0, i[5:4], 2'b0}, 32'h0);
      end
      $display("hash filtering done");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_modes();
      t_hash();
      finish_test();
   end
   // Whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      finish_test();
   end
endmodule // raf_rx_address_filter_tb_top
